// ### common/spp_regs.svh
// Constants of the serial programming port: instruction codes, fields and waits.
// Assumes a 125 MHz system clock; included by the package and the port core.
`ifndef SPP_REGS_SVH
`define SPP_REGS_SVH

`define SYS_CLK_NS 8
`define FLASH_WAIT_NS 4500000
`define EEPROM_WAIT_NS 9000000
`define ERASE_WAIT_NS 9000000

`define INS_ENABLE_B1 8'hac
`define INS_ENABLE_B2 8'h53
`define INS_ERASE_TOP 3'h4
`define INS_LOAD_NIB 4'h4
`define INS_READ_FL_NIB 4'h2
`define INS_LOW_ZERO 3'h0
`define INS_PAGE_WR 8'h4c
`define INS_READ_EE 8'ha0
`define INS_WRITE_EE 8'hc0

`define BIT_LAST_B2 5'h0f
`define BIT_LAST_B3 5'h17
`define BIT_LAST_B4 5'h1f

`define PAGE_WORD_W 5
`define ERASED_BYTE 8'hff
`define CNT_W 21

`endif

// ### common/spp_pkg.sv
// Types shared by the serial programming port and its testbench.
// Assumes spp_regs.svh is on the include path.
`include "spp_regs.svh"

package spp_pkg;

  typedef enum logic [2:0] {
    op_erase = 3'h0,
    op_load_lo = 3'h1,
    op_load_hi = 3'h2,
    op_page_wr = 3'h3,
    op_ee_wr = 3'h4
  } mem_op_t;

  typedef enum logic [1:0] {
    st_off = 2'h0,
    st_sync = 2'h1,
    st_prog = 2'h2
  } sess_t;

  typedef struct packed {
    mem_op_t op;
    logic [11:0] addr;
    logic [7:0] data;
  } cmd_t;

endpackage : spp_pkg

// ### common/cmd_stream_if.sv
// Valid/ready stream carrying memory commands between the port and its FIFO.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface cmd_stream_if #(parameter int W = 23);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : cmd_stream_if

`default_nettype wire

// ### core/cmd_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module cmd_fifo #(
  parameter int W = 23,
  parameter int DEPTH = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Fill and drain sides.
  cmd_stream_if.snk fill,
  cmd_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_ff [DEPTH];
  logic [AW:0] wr_ptr_ff;
  logic [AW:0] rd_ptr_ff;

  wire full = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) && (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire empty = (wr_ptr_ff == rd_ptr_ff);
  wire push = fill.valid && !full;
  wire pop = drain.ready && !empty;

  assign fill.ready = !full;
  assign drain.valid = !empty;
  assign drain.data = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff[AW-1:0]] <= fill.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
      rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
    end
  end
endmodule : cmd_fifo

`default_nettype wire

// ### core/serial_prog_port.sv
// Serial in-system programming port: four-byte instructions on a sampled link,
// memory commands out through a FIFO, reads answered on a same-clock read port.
// Assumes the memory side erases to all ones and performs the page and byte writes.
//
// What this block does
// - Programming is accepted only while the reset pin is held low.
// - Nothing is programmed or erased before the enable instruction executes.
// - A serial EEPROM byte write carries its own automatic erase.
// - Chip erase turns every flash and EEPROM location into all ones.
// - Input bits are sampled on the rising serial clock edge.
// - Output bits change on the falling serial clock edge.
// - Second enable byte echoes during the third; out of sync, nothing acts.
// - Flash is loaded a byte at a time with five low word address bits.
// - A page write with seven high address bits commits the page buffer.
// - EEPROM is written one byte per instruction with address and data.
// - Read instructions return the addressed content on the serial output.
// - Releasing reset high ends programming mode.
// - The enable instruction has two fixed bytes and two don't-care bytes.
// - While a page is written, reads inside that page return all ones.
// - EEPROM write uses a fixed opcode, address high bit, low byte, data.
`timescale 1ns/1ps
`default_nettype none
`include "spp_regs.svh"

module serial_prog_port #(
  parameter int FLASH_WAIT_CYC = `FLASH_WAIT_NS / `SYS_CLK_NS,
  parameter int EEPROM_WAIT_CYC = `EEPROM_WAIT_NS / `SYS_CLK_NS,
  parameter int ERASE_WAIT_CYC = `ERASE_WAIT_NS / `SYS_CLK_NS,
  parameter int FIFO_DEPTH = 32
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic srst,
  // Programming pins.
  input wire logic reset_n_pin,
  input wire logic sck,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // Memory command stream.
  output logic mem_valid,
  input wire logic mem_ready,
  output spp_pkg::mem_op_t mem_op,
  output logic [11:0] mem_addr,
  output logic [7:0] mem_data,
  // Memory read port.
  output logic rd_req,
  output logic rd_eeprom,
  output logic rd_high,
  output logic [11:0] rd_addr,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  // Status.
  output logic prog_active,
  output logic busy
);
  import spp_pkg::*;

  logic rst_s1_ff, rst_s2_ff, sck_s1_ff, sck_s2_ff, sck_d_ff, mosi_s1_ff, mosi_s2_ff;
  sess_t st_ff, nxt_st;
  logic [4:0] bit_cnt_ff;
  logic [30:0] rx_sr_ff;
  logic [7:0] tx_sr_ff;
  logic miso_ff;
  logic poll_ff;
  logic rd_req_ff, rd_ee_ff, rd_hi_ff;
  logic [11:0] rd_addr_ff;
  logic pend_ff;
  cmd_t pend_cmd_ff;
  logic [`CNT_W-1:0] busy_cnt_ff;
  mem_op_t busy_op_ff;
  logic [11:0] busy_addr_ff;

  cmd_stream_if #(.W($bits(cmd_t))) push_if ();
  cmd_stream_if #(.W($bits(cmd_t))) pop_if ();

  // Pins cross into the system clock through two flops before any use.
  always_ff @(posedge sys_clk) begin
    rst_s1_ff <= reset_n_pin;
    rst_s2_ff <= rst_s1_ff;
    sck_s1_ff <= sck;
    sck_s2_ff <= sck_s1_ff;
    sck_d_ff <= sck_s2_ff;
    mosi_s1_ff <= mosi;
    mosi_s2_ff <= mosi_s1_ff;
  end

  // The clock high and low minimums keep each edge visible after the synchroniser.
  wire session = !rst_s2_ff;
  wire sck_rise = sck_s2_ff && !sck_d_ff;
  wire sck_fall = !sck_s2_ff && sck_d_ff;

  // Instruction decode on the word as completed by the current bit.
  wire [31:0] ins_word = {rx_sr_ff, mosi_s2_ff};
  wire [7:0] b1 = ins_word[31:24];
  wire [7:0] b2 = ins_word[23:16];
  wire [7:0] b3 = ins_word[15:8];
  wire [7:0] b4 = ins_word[7:0];
  wire [7:0] r1 = ins_word[23:16];
  wire [7:0] r2 = ins_word[15:8];
  wire [7:0] r3 = ins_word[7:0];
  wire done_b2 = session && sck_rise && (bit_cnt_ff == `BIT_LAST_B2);
  wire done_b3 = session && sck_rise && (bit_cnt_ff == `BIT_LAST_B3);
  wire done_b4 = session && sck_rise && (bit_cnt_ff == `BIT_LAST_B4);

  wire is_enable = (b1 == `INS_ENABLE_B1) && (b2 == `INS_ENABLE_B2);
  wire is_erase = (b1 == `INS_ENABLE_B1) && (b2[7:5] == `INS_ERASE_TOP);
  wire is_load = (b1[7:4] == `INS_LOAD_NIB) && (b1[2:0] == `INS_LOW_ZERO);
  wire is_pgwr = (b1 == `INS_PAGE_WR);
  wire is_eewr = (b1 == `INS_WRITE_EE);
  wire is_mem = is_erase || is_load || is_pgwr || is_eewr;
  wire rd_is_fl = (r1[7:4] == `INS_READ_FL_NIB) && (r1[2:0] == `INS_LOW_ZERO);
  wire rd_is_ee = (r1 == `INS_READ_EE);
  wire [11:0] rd_addr_w = rd_is_ee ? {3'h0, r2[0], r3} : {r2[3:0], r3};

  // Page loads keep only the word-in-page bits; page writes only the page bits.
  wire mem_op_t ex_op = is_erase ? op_erase :
                        is_load ? (b1[3] ? op_load_hi : op_load_lo) :
                        is_pgwr ? op_page_wr : op_ee_wr;
  wire [11:0] ex_addr = is_load ? {7'h0, b3[4:0]} :
                        is_pgwr ? {b2[3:0], b3[7:5], 5'h0} :
                        is_eewr ? {3'h0, b2[0], b3} : 12'h0;
  wire [7:0] ex_data = is_erase ? `ERASED_BYTE : b4;
  wire ex_go = done_b4 && (st_ff == st_prog) && is_mem && !busy && !pend_ff;
  wire ex_timed = ex_go && !is_load;
  wire [`CNT_W-1:0] ex_wait = is_erase ? `CNT_W'(ERASE_WAIT_CYC) :
                              is_pgwr ? `CNT_W'(FLASH_WAIT_CYC) : `CNT_W'(EEPROM_WAIT_CYC);

  // Reads that hit a location still being written answer all ones.
  wire poll_hit = busy && ((busy_op_ff == op_erase) ||
                  (rd_is_fl && busy_op_ff == op_page_wr &&
                   rd_addr_w[11:`PAGE_WORD_W] == busy_addr_ff[11:`PAGE_WORD_W]) ||
                  (rd_is_ee && busy_op_ff == op_ee_wr &&
                   rd_addr_w[8:0] == busy_addr_ff[8:0]));
  wire rd_go = done_b3 && (st_ff == st_prog) && (rd_is_fl || rd_is_ee);

  always_comb begin
    nxt_st = st_ff;
    unique case (st_ff)
      st_off: begin
        if (session) begin
          nxt_st = st_sync;
        end
      end
      st_sync: begin
        if (done_b4 && is_enable) begin
          nxt_st = st_prog;
        end
      end
      st_prog: begin
        nxt_st = st_prog;
      end
      default: begin
        nxt_st = st_off;
      end
    endcase
    if (!session) begin
      nxt_st = st_off;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st_ff <= st_off;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Frame counter and input shift run on rising edges only.
  always_ff @(posedge sys_clk) begin
    if (srst || !session) begin
      bit_cnt_ff <= 5'h0;
      rx_sr_ff <= 31'h0;
    end else if (sck_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 5'h1;
      rx_sr_ff <= ins_word[30:0];
    end
  end

  // Output shift: loaded at byte ends, shifted out on falling edges.
  always_ff @(posedge sys_clk) begin
    if (srst || !session) begin
      tx_sr_ff <= 8'h0;
      miso_ff <= 1'b0;
    end else if (rd_valid) begin
      tx_sr_ff <= poll_ff ? `ERASED_BYTE : rd_data;
    end else if (done_b2) begin
      tx_sr_ff <= b4;
    end else if (done_b3) begin
      tx_sr_ff <= 8'h0;
    end else if (sck_fall) begin
      miso_ff <= tx_sr_ff[7];
      tx_sr_ff <= {tx_sr_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rd_req_ff <= 1'b0;
      rd_ee_ff <= 1'b0;
      rd_hi_ff <= 1'b0;
      rd_addr_ff <= 12'h0;
      poll_ff <= 1'b0;
    end else begin
      rd_req_ff <= rd_go;
      if (rd_go) begin
        rd_ee_ff <= rd_is_ee;
        rd_hi_ff <= r1[3] && rd_is_fl;
        rd_addr_ff <= rd_addr_w;
        poll_ff <= poll_hit;
      end
    end
  end

  // A held command stalls further programming until the FIFO takes it.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      pend_ff <= 1'b0;
      pend_cmd_ff <= '0;
    end else if (ex_go) begin
      pend_ff <= 1'b1;
      pend_cmd_ff <= '{op: ex_op, addr: ex_addr, data: ex_data};
    end else if (push_if.ready) begin
      pend_ff <= 1'b0;
    end
  end

  // Self-timed write window; further writes are refused until it runs out.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_cnt_ff <= '0;
      busy_op_ff <= op_erase;
      busy_addr_ff <= 12'h0;
    end else if (ex_timed) begin
      busy_cnt_ff <= ex_wait;
      busy_op_ff <= ex_op;
      busy_addr_ff <= ex_addr;
    end else if (busy_cnt_ff != '0) begin
      busy_cnt_ff <= busy_cnt_ff - `CNT_W'(1);
    end
  end

  assign push_if.valid = pend_ff;
  assign push_if.data = pend_cmd_ff;
  assign pop_if.ready = mem_ready;

  cmd_fifo #(.W($bits(cmd_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk(sys_clk),
    .srst(srst),
    .fill(push_if.snk),
    .drain(pop_if.src)
  );

  wire cmd_t head = pop_if.data;
  assign mem_valid = pop_if.valid;
  assign mem_op = head.op;
  assign mem_addr = head.addr;
  assign mem_data = head.data;
  assign rd_req = rd_req_ff;
  assign rd_eeprom = rd_ee_ff;
  assign rd_high = rd_hi_ff;
  assign rd_addr = rd_addr_ff;
  assign miso = miso_ff;
  assign miso_oe_n = !session;
  assign prog_active = (st_ff == st_prog);
  assign busy = (busy_cnt_ff != '0);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  sequence s_frame_end;
    done_b4;
  endsequence
  sequence s_enable_seen;
    done_b4 && is_enable && st_ff == st_sync;
  endsequence

  a_locked_before_enable: assert property (!prog_active && !pend_ff |=> !pend_ff)
    else $error("Memory command issued before programming was enabled.");
  a_enable_enters: assert property (s_enable_seen |=> st_ff == st_prog)
    else $error("Enable instruction did not enter programming mode.");
  a_reset_leaves: assert property (!session |=> st_ff == st_off && !prog_active)
    else $error("Programming mode survived a released reset pin.");
  a_frame_wraps: assert property (s_frame_end |=> bit_cnt_ff == 5'h0)
    else $error("Instruction frame did not close after four bytes.");
  a_sample_rise: assert property (session && $changed(bit_cnt_ff) && $past(session)
    |-> $past(sck_rise))
    else $error("Input bit taken without a rising serial clock.");
  a_shift_fall: assert property (session && $past(session) && $changed(miso_ff)
    |-> $past(sck_fall))
    else $error("Output bit changed off a falling serial clock.");
  a_echo_byte: assert property (done_b2 && !rd_valid |=> tx_sr_ff == $past(b4))
    else $error("Second instruction byte not queued for echo.");
  a_poll_ones: assert property (rd_valid && poll_ff && session
    |=> tx_sr_ff == `ERASED_BYTE)
    else $error("Read of a location under write did not return all ones.");
  a_page_fields: assert property (ex_go && is_pgwr |=> pend_cmd_ff.addr[4:0] == 5'h0
    && pend_cmd_ff.op == op_page_wr)
    else $error("Page write carried word bits.");
  a_write_refused: assert property ($rose(pend_ff) |-> !$past(busy))
    else $error("Write accepted during a self-timed write.");
endmodule : serial_prog_port

`default_nettype wire

// ### dv/isp_programmer.sv
// Behavioural in-system programmer driving the reset pin, serial clock and serial data.
// Assumes the device samples on rising and shifts out on falling serial clock edges.
`timescale 1ns/1ps
`default_nettype none

module isp_programmer #(
  parameter real HALF_NS = 62.5,
  parameter int SETTLE_NS = 2000
) (
  // Pins towards the device.
  output logic reset_n_pin,
  output logic sck,
  output logic mosi,
  input wire logic miso
);
  initial begin
    reset_n_pin = 1'b0;
    sck = 1'b0;
    mosi = 1'b0;
  end

  // The settle wait stands in for the long power-up wait, shortened to keep runs brief.
  task power_up();
    reset_n_pin = 1'b0;
    sck = 1'b0;
    #(SETTLE_NS);
  endtask : power_up

  // The clock stays low between frames and data flips after the last bit.
  task xfer(input logic [31:0] ins, output logic [31:0] got);
    for (int i = 31; i >= 0; i--) begin
      mosi = ins[i];
      #(HALF_NS);
      sck = 1'b1;
      got[i] = miso;
      #(HALF_NS);
      sck = 1'b0;
    end
    mosi = ~mosi;
  endtask : xfer

  task set_reset(input logic level);
    sck = 1'b0;
    reset_n_pin = level;
    #(SETTLE_NS);
  endtask : set_reset
endmodule : isp_programmer

`default_nettype wire

// ### dv/tb_top.sv
// Self-checking bench for the serial programming port against a programmer model.
// Assumes the memory is modelled here, answering reads one cycle after the request.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import spp_pkg::*;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic reset_n_pin, sck, mosi, miso, miso_oe_n, mem_valid, rd_req, rd_eeprom, rd_high;
  logic prog_active, busy;
  logic rd_valid = 1'b0;
  logic mem_ready = 1'b0;
  logic hold_ready = 1'b0;
  logic rd_pend = 1'b0;
  mem_op_t mem_op;
  logic [11:0] mem_addr, rd_addr;
  logic [7:0] mem_data;
  logic [7:0] rd_data = 8'h00;
  logic [31:0] got;
  int num_errors = 0;
  int comparisons = 0;
  cmd_t exp_q[$];
  cmd_t got_q[$];

  always #4 sys_clk = ~sys_clk;

  serial_prog_port #(.FLASH_WAIT_CYC(600), .EEPROM_WAIT_CYC(1200), .ERASE_WAIT_CYC(700))
    serial_prog_port_i (.sys_clk(sys_clk), .srst(srst),
    .reset_n_pin(reset_n_pin), .sck(sck), .mosi(mosi), .miso(miso), .miso_oe_n(miso_oe_n),
    .mem_valid(mem_valid), .mem_ready(mem_ready), .mem_op(mem_op), .mem_addr(mem_addr),
    .mem_data(mem_data), .rd_req(rd_req), .rd_eeprom(rd_eeprom), .rd_high(rd_high),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_valid(rd_valid), .prog_active(prog_active),
    .busy(busy));
  isp_programmer isp_programmer_i (.reset_n_pin(reset_n_pin), .sck(sck), .mosi(mosi),
    .miso(miso));

  function automatic logic [7:0] mem_val(input logic ee, input logic hi, input logic [11:0] a);
    return a[7:0] ^ {hi, ee, 6'h2d};
  endfunction : mem_val

  // Memory side: random stalls, and read data that differs per space, half and address.
  always @(posedge sys_clk) begin
    #1;
    mem_ready = !hold_ready && ($urandom % 4 != 0);
    rd_valid = rd_pend;
    rd_data = rd_pend ? mem_val(rd_eeprom, rd_high, rd_addr) : ~rd_data;
    rd_pend = (rd_req === 1'b1);
  end

  always @(posedge sys_clk) begin
    if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
      got_q.push_back(cmd_t'({mem_op, mem_addr, mem_data}));
    end
  end

  task automatic check(input logic [31:0] g, input logic [31:0] e, input string what);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %0t %s: got %h expected %h", $time, what, g, e);
    end
  endtask : check

  task automatic wr(input logic [31:0] ins, input mem_op_t op, input logic [11:0] a,
      input logic [7:0] d);
    exp_q.push_back(cmd_t'{op, a, d});
    isp_programmer_i.xfer(ins, got);
  endtask : wr

  task automatic rd(input logic [31:0] ins, input logic [7:0] e);
    isp_programmer_i.xfer(ins, got);
    check(32'(got[7:0]), 32'(e), "read data");
  endtask : rd

  // Waits out the write window too; a page write carries no meaningful data byte.
  task automatic check_cmds();
    cmd_t c;
    cmd_t e;
    for (int n = 0; n < 3000 && (busy !== 1'b0 || got_q.size() < exp_q.size()); n++)
      @(posedge sys_clk);
    repeat (20) @(posedge sys_clk);
    #1;
    check(got_q.size(), exp_q.size(), "command count");
    while (exp_q.size() > 0 && got_q.size() > 0) begin
      c = got_q.pop_front();
      e = exp_q.pop_front();
      if (e.op == op_page_wr) c.data = e.data;
      check(32'(c), 32'(e), "command");
    end
    got_q.delete();
    exp_q.delete();
  endtask : check_cmds

  task end_of_test();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  initial begin
    #600000;
    num_errors++;
    $display("BAD %0t watchdog expired", $time);
    end_of_test();
  end

  initial begin
    logic [31:0] r;
    logic [6:0] p;
    logic [6:0] q;
    logic [4:0] w;
    logic [8:0] ea;
    void'($urandom(32'he7db));
    repeat (3) @(posedge sys_clk);
    #1 srst = 1'b0;
    isp_programmer_i.power_up();
    check(miso_oe_n, 0, "output enabled in session");
    isp_programmer_i.xfer(32'h4000_0a3c, got);
    isp_programmer_i.xfer(32'hac80_0000, got);
    check_cmds();
    check(prog_active, 0, "inactive before enable");
    r = $urandom;
    isp_programmer_i.xfer({16'hac53, r[15:0]}, got);
    check(32'(got[15:8]), 32'h53, "echo");
    repeat (2) @(posedge sys_clk);
    #1;
    check(prog_active, 1, "enabled");
    wr({8'hac, 3'b100, r[4:0], r[31:16]}, op_erase, 12'h000, 8'hff);
    rd({8'h20, 4'h0, r[27:16], 8'h00}, 8'hff);
    check_cmds();
    for (int k = 0; k < 6; k++) begin
      r = $urandom;
      w = (k == 0) ? 5'h1f : r[4:0];
      wr({8'h40, 4'h0, r[11:5], w, r[19:12]}, op_load_lo, 12'(w), r[19:12]);
      wr({8'h48, 4'h0, r[11:5], w, r[27:20]}, op_load_hi, 12'(w), r[27:20]);
    end
    r = $urandom;
    p = r[6:0];
    q = p + 7'h01;
    wr({8'h4c, 4'h0, p, r[12:8], r[20:13]}, op_page_wr, {p, 5'h00}, 8'h00);
    check(busy, 1, "write window open");
    rd({8'h28, 4'h0, p[6:3], p[2:0], r[25:21], 8'h00}, 8'hff);
    rd({8'h20, 4'h0, q[6:3], q[2:0], r[25:21], 8'h00}, mem_val(0, 0, {q, r[25:21]}));
    check_cmds();
    r = $urandom;
    ea = r[8:0];
    wr({8'hc0, 7'h0, ea, r[16:9]}, op_ee_wr, {3'h0, ea}, r[16:9]);
    // A second byte write inside the window must be dropped, so it is not expected.
    isp_programmer_i.xfer({8'hc0, 7'h0, ~ea, 8'h5a}, got);
    rd({8'ha0, 7'h0, ea[8], ea[7:0], 8'h00}, 8'hff);
    check_cmds();
    rd({8'ha0, 7'h0, ea[8], ea[7:0], 8'h00}, mem_val(1, 0, {3'h0, ea}));
    rd({8'h28, 4'h0, r[27:16], 8'h00}, mem_val(0, 1, r[27:16]));
    // With the memory stalled, 32 entries fill the FIFO, one more is held, the rest drop.
    hold_ready = 1'b1;
    for (int k = 0; k < 34; k++) begin
      r = $urandom;
      if (k < 33) exp_q.push_back(cmd_t'{op_load_lo, {7'h0, r[4:0]}, r[12:5]});
      isp_programmer_i.xfer({16'h4000, 3'h0, r[4:0], r[12:5]}, got);
    end
    check(mem_valid, 1, "head stands while stalled");
    hold_ready = 1'b0;
    check_cmds();
    isp_programmer_i.set_reset(1'b1);
    check(prog_active, 0, "session left");
    check(miso_oe_n, 1, "output released");
    isp_programmer_i.set_reset(1'b0);
    isp_programmer_i.xfer(32'hc000_1234, got);
    check_cmds();
    isp_programmer_i.xfer(32'hac53_0000, got);
    check(32'(got[15:8]), 32'h53, "echo in new session");
    end_of_test();
  end
endmodule : tb_top

`default_nettype wire
